// file: bench/uefc_far_model.sv
// far-side receiver model: moves the rx fifo count, one char every other cycle
`timescale 1ns/1ps
module uefc_far_model (
	input  wire logic       i_clk,
	input  wire logic       i_rstn,
	input  wire logic [8:0] i_target,
	output logic      [8:0] o_rx_count,
	output logic            o_rx_char
);
	logic gap_reg;
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			o_rx_count <= 9'h000;
			o_rx_char  <= 1'b0;
			gap_reg    <= 1'b0;
		end else begin
			gap_reg   <= ~gap_reg;
			o_rx_char <= 1'b0;
			if (!gap_reg && o_rx_count < i_target) begin
				o_rx_count <= o_rx_count + 9'h001;
				o_rx_char  <= 1'b1;
			end else if (!gap_reg && o_rx_count > i_target) begin
				o_rx_count <= o_rx_count - 9'h001;
			end
		end
	end
endmodule

// file: bench/uefc_top_tb.sv
// self-checking bench of the extended-page uart flow block
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin err_total++; \
	$display("[ERR] %s expected %0h seen %0h", nm, ex, got); end end
module uefc_top_tb;
	import uefc_pkg::*;
	logic        clk, rstn, cyc, stb, wb_we, drv_sel, xoff, xon, rts_n, oe, irq, rx_char, tmo;
	logic [7:0]  adr, q;
	logic [8:0]  target, tx_cnt, rx_count;
	logic [31:0] wdat, rdat;
	logic        ack;
	int          checks, err_total, n_xoff, n_xon, base, c;
	int          resend_n [4] = '{1, 4, 8, 16};
	// ----------------------------------------------------------------
	// clock, partner, design
	// ----------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	uefc_far_model uefc_far_model_inst (.i_clk(clk), .i_rstn(rstn), .i_target(target),
		.o_rx_count(rx_count), .o_rx_char(rx_char));
	uefc_top uefc_top_inst (.I_CLK(clk), .I_RSTN(rstn), .I_WB_CYC(cyc), .I_WB_STB(stb),
		.I_WB_WE(wb_we), .I_WB_ADR(adr), .I_WB_SEL(4'h1), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
		.O_WB_ACK(ack), .I_RX_COUNT(rx_count), .I_TX_COUNT(tx_cnt), .I_RX_CHAR(rx_char),
		.I_RX_TIMEOUT(tmo), .I_TXD_CORE(1'b0), .I_LINE_DRIVER_ENABLE_CORE(1'b1),
		.I_RECEIVER_ENABLE_N_CORE(1'b1), .O_SEND_XOFF(xoff), .O_SEND_XON(xon),
		.I_MODEM_N(4'hf), .I_IRQ_DRIVE_SELECT(drv_sel), .O_TXD(), .O_RTS_N(rts_n),
		.O_DTR_N(), .O_LINE_DRIVER_ENABLE(), .O_RECEIVER_ENABLE_N(), .O_INT(irq),
		.O_INT_OE(oe));
	always @(posedge clk) begin
		if (xoff === 1'b1) n_xoff++;
		if (xon === 1'b1) n_xon++;
	end
	// ----------------------------------------------------------------
	// bus and helper tasks
	// ----------------------------------------------------------------
	task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		int n;
		begin
			n = 0;
			cyc   <= 1'b1;
			stb   <= 1'b1;
			wb_we <= w;
			adr   <= a;
			wdat  <= {24'h0, d};
			do begin
				@(posedge clk);
				n++;
			end while (ack !== 1'b1 && n < 20);
			if (n >= 20) err_total++;
			q = rdat[7:0];
			cyc <= 1'b0;
			stb <= 1'b0;
			@(posedge clk);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		xfer(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] ex, input string nm);
		xfer(1'b0, a, 8'h00);
		`CHK(nm, ex, q)
	endtask
	task fill(input logic [8:0] v);
		int n;
		begin
			target <= v;
			n = 0;
			@(posedge clk);
			while (rx_count !== v && n < 600) begin
				@(posedge clk);
				n++;
			end
			if (n >= 600) err_total++;
			repeat (3) @(posedge clk);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		end_sim;
	end
	// ----------------------------------------------------------------
	// tests
	// ----------------------------------------------------------------
	initial begin
		rstn = 1'b0; cyc = 1'b0; stb = 1'b0; wb_we = 1'b0; adr = 8'h00; wdat = 32'h0;
		target = 9'h000; tx_cnt = 9'h000; drv_sel = 1'b1; checks = 0; err_total = 0;
		n_xoff = 0; n_xon = 0; tmo = 1'b0;
		repeat (4) @(posedge clk);
		`CHK("txd", 1'b1, uefc_top_inst.O_TXD)
		`CHK("rts", 1'b1, rts_n)
		`CHK("dtr", 1'b1, uefc_top_inst.O_DTR_N)
		`CHK("line drv", 1'b0, uefc_top_inst.O_LINE_DRIVER_ENABLE)
		`CHK("rx enable", 1'b0, uefc_top_inst.O_RECEIVER_ENABLE_N)
		rstn <= 1'b1;
		@(posedge clk);
		rd(ADR_INT_STATUS, 8'h01, "int_status");
		rd(ADR_LINE_STATUS, 8'h60, "line_status");
		rd(ADR_DIVISOR_LOW, 8'hff, "divisor_low");
		rd(ADR_DIVISOR_HIGH, 8'hff, "divisor_high");
		rd(ADR_MODEM_CONTROL, 8'h00, "modem_control");
		rd(ADR_MODEM_STATUS, 8'h00, "modem_status");
		`CHK("int drive", 1'b1, oe)
		`CHK("int level", 1'b0, irq)
		rd(ADR_TX_TRIGGER, 8'h00, "closed page");
		rd(8'h44, 8'h00, "unmapped");
		`CHK("txd core", 1'b0, uefc_top_inst.O_TXD)
		`CHK("line drv core", 1'b1, uefc_top_inst.O_LINE_DRIVER_ENABLE)
		`CHK("rx enable core", 1'b1, uefc_top_inst.O_RECEIVER_ENABLE_N)
		$display("test reset done");
		wr(ADR_FIFO_CONTROL, 8'ha1);
		wr(ADR_LINE_CONTROL, EXT_SPACE_KEY);
		wr(ADR_PAGE_SELECT, {PAGE_ACCESS_KEY, 1'b1});
		rd(ADR_TX_TRIGGER, 8'h80, "tx_trigger");
		rd(ADR_RX_TRIGGER, 8'h80, "rx_trigger");
		wr(ADR_RX_TRIGGER, 8'h7f);
		rd(ADR_RX_TRIGGER, 8'h7f, "rx_trigger written");
		wr(ADR_RX_TRIGGER, TRIGGER_RESET);
		wr(ADR_FLOW_UPPER, 8'h55);
		rd(ADR_FLOW_UPPER, 8'h38, "upper 64");
		rd(ADR_FLOW_LOWER, 8'h10, "lower 64");
		wr(ADR_FIFO_DEPTH, 8'hff);
		rd(ADR_FIFO_DEPTH, 8'h01, "fifo_depth");
		wr(ADR_XOFF_RESEND, 8'hff);
		rd(ADR_XOFF_RESEND, 8'h03, "xoff_resend");
		wr(ADR_FLOW_UPPER, 8'h20);
		rd(ADR_FLOW_UPPER, 8'h00, "upper gated");
		wr(ADR_PAGE_SELECT, {PAGE_ACCESS_KEY, 1'b0});
		wr(ADR_PAGE_SELECT, 8'h03);
		rd(ADR_FIFO_DEPTH, 8'h00, "wrong key");
		wr(ADR_ENH_FEATURE, 8'h48);
		wr(ADR_PAGE_SELECT, {PAGE_ACCESS_KEY, 1'b1});
		wr(ADR_FLOW_UPPER, 8'h20);
		wr(ADR_FLOW_LOWER, 8'h10);
		rd(ADR_FLOW_UPPER, 8'h20, "upper");
		rd(ADR_FLOW_LOWER, 8'h10, "lower");
		$display("test registers done");
		`CHK("rts open", 1'b0, rts_n)
		fill(9'h021);
		`CHK("xoff sent", 1, n_xoff)
		`CHK("rts full", 1'b1, rts_n)
		wr(ADR_XOFF_RESEND, 8'h00);
		fill(rx_count + 9'h002);
		`CHK("resend off", 1, n_xoff)
		wr(ADR_MODEM_CONTROL, 8'h04);
		for (c = 0; c < 4; c++) begin
			wr(ADR_XOFF_RESEND, c[7:0]);
			base = n_xoff;
			fill(rx_count + 9'(resend_n[c] - 1));
			`CHK("early resend", base, n_xoff)
			fill(rx_count + 9'h001);
			`CHK("resend", base + 1, n_xoff)
		end
		fill(9'h00f);
		`CHK("xon sent", 1, n_xon)
		`CHK("rts drained", 1'b0, rts_n)
		$display("test flow done");
		wr(ADR_INT_ENABLE, 8'h03);
		rd(ADR_INT_STATUS, 8'h82, "tx irq");
		`CHK("int pin", 1'b1, irq)
		tx_cnt <= 9'h080;
		fill(9'h080);
		rd(ADR_INT_STATUS, 8'h01, "at levels");
		tmo <= 1'b1;
		@(posedge clk);
		rd(ADR_INT_STATUS, 8'h0c, "timeout irq");
		`CHK("int timeout pin", 1'b1, irq)
		tmo <= 1'b0;
		fill(9'h081);
		rd(ADR_INT_STATUS, 8'h04, "rx irq");
		fill(9'h100);
		rd(ADR_INT_STATUS, 8'h44, "rx full");
		drv_sel <= 1'b0;
		repeat (6) @(posedge clk);
		`CHK("int float", 1'b0, oe)
		$display("test interrupts done");
		end_sim;
	end
endmodule

// file: rtl/uefc_pkg.sv
// constants of the extended-page uart flow block
package uefc_pkg;
	// --------------------------------------------------------------
	// register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] ADR_LINE_CONTROL   = 8'h00;
	localparam logic [7:0] ADR_MODEM_CONTROL  = 8'h04;
	localparam logic [7:0] ADR_FIFO_CONTROL   = 8'h08;
	localparam logic [7:0] ADR_INT_STATUS     = 8'h0c;
	localparam logic [7:0] ADR_LINE_STATUS    = 8'h10;
	localparam logic [7:0] ADR_MODEM_STATUS   = 8'h14;
	localparam logic [7:0] ADR_DIVISOR_LOW    = 8'h18;
	localparam logic [7:0] ADR_DIVISOR_HIGH   = 8'h1c;
	localparam logic [7:0] ADR_PAGE_SELECT    = 8'h20;
	localparam logic [7:0] ADR_ENH_FEATURE    = 8'h24;
	localparam logic [7:0] ADR_FIFO_DEPTH     = 8'h28;
	localparam logic [7:0] ADR_XOFF_RESEND    = 8'h2c;
	localparam logic [7:0] ADR_TX_TRIGGER     = 8'h30;
	localparam logic [7:0] ADR_RX_TRIGGER     = 8'h34;
	localparam logic [7:0] ADR_FLOW_UPPER     = 8'h38;
	localparam logic [7:0] ADR_FLOW_LOWER     = 8'h3c;
	localparam logic [7:0] ADR_INT_ENABLE     = 8'h40;
	// --------------------------------------------------------------
	// keys, reset values, field positions
	// --------------------------------------------------------------
	localparam logic [7:0] EXT_SPACE_KEY      = 8'hbf;
	localparam logic [6:0] PAGE_ACCESS_KEY    = 7'h52;
	localparam logic [7:0] ISR_RESET          = 8'h01;
	localparam logic [7:0] LSR_RESET          = 8'h60;
	localparam logic [7:0] DIVISOR_RESET      = 8'hff;
	localparam logic [7:0] TRIGGER_RESET      = 8'h80;
	localparam logic [2:0] ISR_ID_RX          = 3'h2;
	localparam logic [2:0] ISR_ID_TIMEOUT     = 3'h6;
	localparam logic [2:0] ISR_ID_TX          = 3'h1;
	localparam int         MCR_DTR_BIT        = 0;
	localparam int         MCR_RTS_BIT        = 1;
	localparam int         MCR_RESEND_BIT     = 2;
	localparam int         EFR_AUTO_RTS_BIT   = 6;
	localparam int         FCR_ENABLE_BIT     = 0;
	localparam int         IER_RX_BIT         = 0;
	localparam int         IER_TX_BIT         = 1;
	localparam int         FIFO256_DEPTH      = 256;
	// --------------------------------------------------------------
	// 64-byte mode levels, indexed by fifo_control fields
	// --------------------------------------------------------------
	localparam logic [7:0] FLOW_UPPER_64 [4]  = '{8'h08, 8'h10, 8'h38, 8'h3c};
	localparam logic [7:0] FLOW_LOWER_64 [4]  = '{8'h00, 8'h08, 8'h10, 8'h38};
	localparam logic [7:0] RX_TRIGGER_64 [4]  = '{8'h08, 8'h10, 8'h38, 8'h3c};
	localparam logic [7:0] TX_TRIGGER_64 [4]  = '{8'h08, 8'h10, 8'h20, 8'h38};
	// resend period minus one for codes 00..11 (1, 4, 8, 16)
	localparam logic [3:0] RESEND_LAST [4]    = '{4'h0, 4'h3, 4'h7, 4'hf};
endpackage

// file: rtl/uefc_top.sv
// extended-page uart block: deep fifo mode, triggers, flow control, reset state
//
// Decided for this implementation: the Wishbone slave port and the placing of the registers.
`timescale 1ns/1ps
module uefc_top
	import uefc_pkg::*;
#(
	parameter int COUNT_W = 9
) (
	// clock and reset
	input  wire logic               I_CLK,
	input  wire logic               I_RSTN,
	// wishbone slave
	input  wire logic               I_WB_CYC,
	input  wire logic               I_WB_STB,
	input  wire logic               I_WB_WE,
	input  wire logic [7:0]         I_WB_ADR,
	input  wire logic [3:0]         I_WB_SEL,
	input  wire logic [31:0]        I_WB_DAT,
	output logic      [31:0]        O_WB_DAT,
	output logic                    O_WB_ACK,
	// uart core status
	input  wire logic [COUNT_W-1:0] I_RX_COUNT,
	input  wire logic [COUNT_W-1:0] I_TX_COUNT,
	input  wire logic               I_RX_CHAR,
	input  wire logic               I_RX_TIMEOUT,
	input  wire logic               I_TXD_CORE,
	input  wire logic               I_LINE_DRIVER_ENABLE_CORE,
	input  wire logic               I_RECEIVER_ENABLE_N_CORE,
	// flow characters to the transmitter
	output logic                    O_SEND_XOFF,
	output logic                    O_SEND_XON,
	// pins
	input  wire logic [3:0]         I_MODEM_N,
	input  wire logic               I_IRQ_DRIVE_SELECT,
	output logic                    O_TXD,
	output logic                    O_RTS_N,
	output logic                    O_DTR_N,
	output logic                    O_LINE_DRIVER_ENABLE,
	output logic                    O_RECEIVER_ENABLE_N,
	output logic                    O_INT,
	output logic                    O_INT_OE
);

	generate
		if (COUNT_W < 9 || COUNT_W > 16) begin : g_check
			$error("COUNT_W must lie in 9..16");
		end
	endgenerate

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic       wb_ack;
		logic [7:0] wb_dat;
		logic [7:0] line_control;
		logic [7:0] modem_control;
		logic [7:0] fifo_control;
		logic [7:0] int_enable;
		logic [7:0] divisor_low;
		logic [7:0] divisor_high;
		logic [7:0] enhanced_feature_ctrl;
		logic       page4;
		logic       deep_fifo;
		logic [1:0] xoff_resend_count;
		logic [7:0] tx_trigger_level;
		logic [7:0] rx_trigger_level;
		logic [7:0] flow_upper_threshold;
		logic [7:0] flow_lower_threshold;
		logic [7:0] interrupt_status;
		logic [7:0] line_status;
		logic [7:0] modem_status;
		logic       xoff_sent;
		logic [3:0] resend_cnt;
		logic       send_xoff;
		logic       send_xon;
		logic       rts_hold;
		logic       txd;
		logic       line_drv;
		logic       rcv_en_n;
		logic       int_out;
		logic [4:0] pin_s1;
		logic [4:0] pin_s2;
		logic [4:0] pin_s3;
		logic [4:0] pin_stable;
	} uefc_state_type;

	uefc_state_type st_reg;
	uefc_state_type st_next;

	logic                wb_req;
	logic                wb_wr;
	logic [7:0]          wdat;
	logic                ext_space;
	logic                page3_on;
	logic                page4_on;
	logic                sw_tx_flow;
	logic                auto_rts;
	logic                resend_on;
	logic                thr_writable;
	logic [7:0]          upper_eff;
	logic [7:0]          lower_eff;
	logic [7:0]          rx_level;
	logic [7:0]          tx_level;
	logic                above_upper;
	logic                below_lower;
	logic                rx_irq;
	logic                tmo_irq;
	logic                tx_irq;
	logic [7:0]          rdat;

	// --------------------------------------------------------------
	// decode and flow terms
	// --------------------------------------------------------------
	assign wb_req       = I_WB_CYC & I_WB_STB;
	assign wb_wr        = wb_req & I_WB_WE & I_WB_SEL[0] & st_reg.wb_ack;
	assign wdat         = I_WB_DAT[7:0];
	assign ext_space    = st_reg.line_control == EXT_SPACE_KEY;
	assign page3_on     = ext_space & ~st_reg.page4;
	assign page4_on     = ext_space & st_reg.page4;
	assign sw_tx_flow   = st_reg.enhanced_feature_ctrl[3:2] != 2'b00;
	assign auto_rts     = st_reg.enhanced_feature_ctrl[EFR_AUTO_RTS_BIT];
	assign resend_on    = (st_reg.enhanced_feature_ctrl[3:0] != 4'h0)
		& st_reg.modem_control[MCR_RESEND_BIT];
	assign thr_writable = st_reg.deep_fifo & (sw_tx_flow | auto_rts);
	assign upper_eff    = st_reg.deep_fifo ? st_reg.flow_upper_threshold
		: FLOW_UPPER_64[st_reg.fifo_control[5:4]];
	assign lower_eff    = st_reg.deep_fifo ? st_reg.flow_lower_threshold
		: FLOW_LOWER_64[st_reg.fifo_control[7:6]];
	assign rx_level     = st_reg.deep_fifo ? st_reg.rx_trigger_level
		: RX_TRIGGER_64[st_reg.fifo_control[7:6]];
	assign tx_level     = st_reg.deep_fifo ? st_reg.tx_trigger_level
		: TX_TRIGGER_64[st_reg.fifo_control[5:4]];
	// thresholds are assumed ordered, so above and below never coincide
	assign above_upper  = I_RX_COUNT > COUNT_W'(upper_eff);
	assign below_lower  = I_RX_COUNT < COUNT_W'(lower_eff);

	// a zero trigger level is not guarded against
	always_comb begin
		rx_irq  = 1'b0;
		tx_irq  = 1'b0;
		tmo_irq = st_reg.int_enable[IER_RX_BIT] & I_RX_TIMEOUT;
		if (st_reg.fifo_control[FCR_ENABLE_BIT]) begin
			rx_irq = I_RX_COUNT > COUNT_W'(rx_level);
			tx_irq = I_TX_COUNT < COUNT_W'(tx_level);
		end else begin
			rx_irq = I_RX_COUNT != '0;
			tx_irq = I_TX_COUNT == '0;
		end
		rx_irq = rx_irq & st_reg.int_enable[IER_RX_BIT];
		tx_irq = tx_irq & st_reg.int_enable[IER_TX_BIT];
	end

	// --------------------------------------------------------------
	// read mux
	// --------------------------------------------------------------
	always_comb begin
		rdat = 8'h00;
		case (I_WB_ADR)
			ADR_LINE_CONTROL: rdat = st_reg.line_control;
			ADR_MODEM_CONTROL: rdat = st_reg.modem_control;
			ADR_FIFO_CONTROL: rdat = st_reg.fifo_control;
			ADR_INT_STATUS: rdat = st_reg.interrupt_status;
			ADR_LINE_STATUS: rdat = st_reg.line_status;
			ADR_MODEM_STATUS: rdat = st_reg.modem_status;
			ADR_DIVISOR_LOW: rdat = st_reg.divisor_low;
			ADR_DIVISOR_HIGH: rdat = st_reg.divisor_high;
			ADR_INT_ENABLE: rdat = st_reg.int_enable;
			ADR_PAGE_SELECT: rdat = ext_space ? {7'h00, st_reg.page4} : 8'h00;
			ADR_ENH_FEATURE: rdat = page3_on ? st_reg.enhanced_feature_ctrl : 8'h00;
			ADR_FIFO_DEPTH: rdat = page4_on ? {7'h00, st_reg.deep_fifo} : 8'h00;
			ADR_XOFF_RESEND: rdat = page4_on ? {6'h00, st_reg.xoff_resend_count} : 8'h00;
			ADR_TX_TRIGGER: rdat = page4_on ? st_reg.tx_trigger_level : 8'h00;
			ADR_RX_TRIGGER: rdat = page4_on ? st_reg.rx_trigger_level : 8'h00;
			ADR_FLOW_UPPER: rdat = page4_on ? upper_eff : 8'h00;
			ADR_FLOW_LOWER: rdat = page4_on ? lower_eff : 8'h00;
			default: rdat = 8'h00;
		endcase
	end

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		st_next = st_reg;
		st_next.wb_ack = wb_req & ~st_reg.wb_ack;
		if (wb_req & ~st_reg.wb_ack) begin
			st_next.wb_dat = rdat;
		end
		// pin synchronisers, a change counts once stages two and three agree
		st_next.pin_s1 = {I_IRQ_DRIVE_SELECT, I_MODEM_N};
		st_next.pin_s2 = st_reg.pin_s1;
		st_next.pin_s3 = st_reg.pin_s2;
		if (st_reg.pin_s2 == st_reg.pin_s3) begin
			st_next.pin_stable = st_reg.pin_s3;
		end
		// modem status: inverted levels low, sticky change flags high
		if (wb_req & ~I_WB_WE & st_reg.wb_ack & (I_WB_ADR == ADR_MODEM_STATUS)) begin
			st_next.modem_status[7:4] = 4'h0;
		end
		st_next.modem_status[7:4] = st_next.modem_status[7:4]
			| (st_reg.pin_stable[3:0] ^ st_next.pin_stable[3:0]);
		st_next.modem_status[3:0] = ~st_reg.pin_stable[3:0];
		// register writes at the acknowledging edge
		if (wb_wr) begin
			case (I_WB_ADR)
				ADR_LINE_CONTROL: st_next.line_control = wdat;
				ADR_MODEM_CONTROL: st_next.modem_control = wdat;
				ADR_FIFO_CONTROL: st_next.fifo_control = wdat;
				ADR_DIVISOR_LOW: st_next.divisor_low = wdat;
				ADR_DIVISOR_HIGH: st_next.divisor_high = wdat;
				ADR_INT_ENABLE: st_next.int_enable = wdat;
				ADR_PAGE_SELECT: begin
					if (ext_space && wdat[7:1] == PAGE_ACCESS_KEY) begin
						st_next.page4 = wdat[0];
					end
				end
				ADR_ENH_FEATURE: begin
					if (page3_on) begin
						st_next.enhanced_feature_ctrl = wdat;
					end
				end
				ADR_FIFO_DEPTH: begin
					if (page4_on) begin
						st_next.deep_fifo = wdat[0];
					end
				end
				ADR_XOFF_RESEND: begin
					if (page4_on) begin
						st_next.xoff_resend_count = wdat[1:0];
					end
				end
				ADR_TX_TRIGGER: begin
					if (page4_on) begin
						st_next.tx_trigger_level = wdat;
					end
				end
				ADR_RX_TRIGGER: begin
					if (page4_on) begin
						st_next.rx_trigger_level = wdat;
					end
				end
				ADR_FLOW_UPPER: begin
					if (page4_on && thr_writable) begin
						st_next.flow_upper_threshold = wdat;
					end
				end
				ADR_FLOW_LOWER: begin
					if (page4_on && thr_writable) begin
						st_next.flow_lower_threshold = wdat;
					end
				end
				default: st_next.line_control = st_next.line_control;
			endcase
		end
		// software flow: xoff above upper, xon below lower, periodic resend
		st_next.send_xoff = 1'b0;
		st_next.send_xon  = 1'b0;
		if (sw_tx_flow) begin
			if (above_upper && !st_reg.xoff_sent) begin
				st_next.send_xoff  = 1'b1;
				st_next.xoff_sent  = 1'b1;
				st_next.resend_cnt = 4'h0;
			end else if (below_lower && st_reg.xoff_sent) begin
				st_next.send_xon  = 1'b1;
				st_next.xoff_sent = 1'b0;
			end else if (st_reg.xoff_sent && resend_on && I_RX_CHAR) begin
				if (st_reg.resend_cnt == RESEND_LAST[st_reg.xoff_resend_count]) begin
					st_next.send_xoff  = 1'b1;
					st_next.resend_cnt = 4'h0;
				end else begin
					st_next.resend_cnt = st_reg.resend_cnt + 4'h1;
				end
			end
		end else begin
			st_next.xoff_sent = 1'b0;
		end
		// automatic rts, holds between the thresholds
		if (above_upper) begin
			st_next.rts_hold = 1'b1;
		end else if (below_lower) begin
			st_next.rts_hold = 1'b0;
		end
		// status
		st_next.interrupt_status[7:6] = st_reg.deep_fifo
			? {I_TX_COUNT == '0, I_RX_COUNT == COUNT_W'(FIFO256_DEPTH)}
			: {2{st_reg.fifo_control[FCR_ENABLE_BIT]}};
		st_next.interrupt_status[5:4] = 2'b00;
		st_next.interrupt_status[0]   = ~(rx_irq | tmo_irq | tx_irq);
		if (rx_irq) begin
			st_next.interrupt_status[3:1] = ISR_ID_RX;
		end else if (tmo_irq) begin
			st_next.interrupt_status[3:1] = ISR_ID_TIMEOUT;
		end else if (tx_irq) begin
			st_next.interrupt_status[3:1] = ISR_ID_TX;
		end else begin
			st_next.interrupt_status[3:1] = 3'h0;
		end
		st_next.line_status = {1'b0, {2{I_TX_COUNT == '0}}, 4'h0, I_RX_COUNT != '0};
		st_next.int_out     = rx_irq | tmo_irq | tx_irq;
		st_next.txd         = I_TXD_CORE;
		st_next.line_drv    = I_LINE_DRIVER_ENABLE_CORE;
		st_next.rcv_en_n    = I_RECEIVER_ENABLE_N_CORE;
		if (!I_RSTN) begin
			st_next                       = '0;
			st_next.pin_s1                = {I_IRQ_DRIVE_SELECT, I_MODEM_N};
			st_next.pin_s2                = st_reg.pin_s1;
			st_next.pin_s3                = st_reg.pin_s2;
			st_next.pin_stable            = st_reg.pin_s3;
			st_next.modem_status          = {4'h0, ~st_reg.pin_stable[3:0]};
			st_next.interrupt_status      = ISR_RESET;
			st_next.line_status           = LSR_RESET;
			st_next.divisor_low           = DIVISOR_RESET;
			st_next.divisor_high          = DIVISOR_RESET;
			st_next.tx_trigger_level      = TRIGGER_RESET;
			st_next.rx_trigger_level      = TRIGGER_RESET;
			st_next.txd                   = 1'b1;
			st_next.rcv_en_n              = 1'b0;
		end
	end

	always_ff @(posedge I_CLK) begin
		st_reg <= st_next;
	end

	// --------------------------------------------------------------
	// outputs
	// --------------------------------------------------------------
	assign O_WB_ACK             = st_reg.wb_ack;
	assign O_WB_DAT             = {24'h000000, st_reg.wb_dat};
	assign O_SEND_XOFF          = st_reg.send_xoff;
	assign O_SEND_XON           = st_reg.send_xon;
	assign O_TXD                = st_reg.txd;
	assign O_RTS_N              = auto_rts ? st_reg.rts_hold
		: ~st_reg.modem_control[MCR_RTS_BIT];
	assign O_DTR_N              = ~st_reg.modem_control[MCR_DTR_BIT];
	assign O_LINE_DRIVER_ENABLE = st_reg.line_drv;
	assign O_RECEIVER_ENABLE_N  = st_reg.rcv_en_n;
	assign O_INT                = st_reg.int_out;
	assign O_INT_OE             = st_reg.pin_stable[4];

	// --------------------------------------------------------------
	// assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (!I_RSTN);

	a_depth_upper_zero: assert property (
		O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_FIFO_DEPTH |-> O_WB_DAT[7:1] == 7'h00)
		else $error("depth feature upper bits not zero");
	a_resend_upper_zero: assert property (
		O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_XOFF_RESEND |-> O_WB_DAT[7:2] == 6'h00)
		else $error("resend count upper bits not zero");
	a_page4_gated: assert property (
		O_WB_ACK && !I_WB_WE && I_WB_ADR == ADR_TX_TRIGGER && !page4_on
		|-> O_WB_DAT == 32'h0)
		else $error("page 4 readable outside its space");
	a_page_key_bad: assert property (
		wb_wr && I_WB_ADR == ADR_PAGE_SELECT && wdat[7:1] != PAGE_ACCESS_KEY
		|=> $stable(st_reg.page4))
		else $error("page changed without key");
	a_upper_locked: assert property (
		wb_wr && I_WB_ADR == ADR_FLOW_UPPER && !thr_writable
		|=> $stable(st_reg.flow_upper_threshold))
		else $error("upper threshold written while locked");
	a_xoff_on_upper: assert property (
		sw_tx_flow && above_upper && !st_reg.xoff_sent
		|=> O_SEND_XOFF ##1 (!O_SEND_XOFF || $past(I_RX_CHAR)) [*2])
		else $error("xoff not sent once above upper");
	a_xon_after_xoff: assert property (
		O_SEND_XON |-> $past(st_reg.xoff_sent) && $past(below_lower))
		else $error("xon without earlier xoff");
	a_auto_rts_high: assert property (
		auto_rts && above_upper ##1 auto_rts |-> O_RTS_N)
		else $error("rts not raised above upper");
	a_deep_isr_empty: assert property (
		st_reg.deep_fifo |=> st_reg.interrupt_status[7]
		== ($past(I_TX_COUNT) == '0))
		else $error("deep tx empty flag wrong");
	a_trigger_reset: assert property (@(posedge I_CLK)
		$rose(I_RSTN) |-> st_reg.tx_trigger_level == TRIGGER_RESET
		&& st_reg.rx_trigger_level == TRIGGER_RESET)
		else $error("trigger level reset value wrong");
	a_reset_pins: assert property (@(posedge I_CLK) disable iff (1'b0)
		!I_RSTN |=> O_TXD && O_DTR_N && !O_LINE_DRIVER_ENABLE && !O_RECEIVER_ENABLE_N)
		else $error("pin reset state wrong");
	a_int_drive: assert property (
		$past(I_IRQ_DRIVE_SELECT, 4) == $past(I_IRQ_DRIVE_SELECT, 3)
		|-> O_INT_OE == $past(I_IRQ_DRIVE_SELECT, 4))
		else $error("interrupt drive enable wrong");

endmodule
